// file: verilog/eamr_pkg.sv
// constants and types shared by the audio mixer/router and its level meter
// assumes one audio-side clock; all config and sample ports are on that clock
// How it works
// - embed group g carries mixer outputs 4g..4g+3
// - group embedded only when its enable is on
// - aes port is input or output, never both
// - encoder takes exactly the selected sdi pair
// - encoder to aes only on output ports
// - reset gives normal mode and independent gains
// - paired mode links odd/even partner gains
// - surround 5.1 has six channel roles
// - surround 7.1 adds left and right rear
// - linked group shares gain and automatic gain
// - sixteen inputs, sixteen busses, assignment matrix
// - matrix resets to input n on bus n
// - any fan-out and fan-in is allowed
// - gain only on inputs, none on busses
// - auto gain needs channel bit and master
// - mixer pair n feeds sdi and aes pair n
// - sdi source offers eight embedded pairs
// - aes source offers four port pairs
// - analog source offers pairs 1/2, 3/4
// - decoder pairs, six or eight valid channels
// - four selector groups of two pairs each
// - level averaged over configurable window
// - data pairs bypass mixer bit-exact
// - strip removes incoming embedded audio
package eamr_pkg;
    localparam int NCH       = 16;
    localparam int NPAIR     = 8;
    localparam int NGRP      = 4;
    localparam int NAES      = 4;
    localparam int GAIN_FRAC = 6;
    localparam logic [7:0] GAIN_UNITY = 8'h40;
    // source kinds of a mixer input pair
    localparam logic [1:0] SRC_SDI    = 2'h0;
    localparam logic [1:0] SRC_AES    = 2'h1;
    localparam logic [1:0] SRC_DECODE = 2'h2;
    localparam logic [1:0] SRC_ANALOG = 2'h3;
    // per-pair sample handling
    localparam logic [1:0] PM_AUDIO = 2'h0;
    localparam logic [1:0] PM_DATA  = 2'h1;
    localparam logic [1:0] PM_AUTO  = 2'h2;
    // per-channel mix mode and surround roles
    localparam logic [3:0] MIX_NORMAL = 4'h0;
    localparam logic [3:0] MIX_PAIRED = 4'h1;
    localparam logic [3:0] MIX_LEFT   = 4'h2;
    localparam logic [3:0] MIX_RIGHT  = 4'h3;
    localparam logic [3:0] MIX_CENTER = 4'h4;
    localparam logic [3:0] MIX_LSURR  = 4'h5;
    localparam logic [3:0] MIX_RSURR  = 4'h6;
    localparam logic [3:0] MIX_BASS   = 4'h7;
    localparam logic [3:0] MIX_LREAR  = 4'h8;
    localparam logic [3:0] MIX_RREAR  = 4'h9;
    // decoder channel counts for the two codec kinds
    localparam logic [3:0] DEC_CH_51 = 4'h6;
    localparam logic [3:0] DEC_CH_71 = 4'h8;
    // bus saturation limits at accumulator width
    localparam logic signed [32:0] ACC_MAX = 33'sh0007FFFFF;
    localparam logic signed [32:0] ACC_MIN = 33'sh1FF800000;
    // level meter timing
    localparam logic [15:0] SAMPLE_RATE_HZ   = 16'hBB80;
    localparam logic [7:0]  WINDOW_TYPICAL_S = 8'h0A;
    typedef logic signed [23:0] eamr_smp_t;
endpackage : eamr_pkg

// file: verilog/eamr_meter_if.sv
// carrier between the mixer/router and its level meter
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface eamr_meter_if;
    logic                strobe;
    logic signed [23:0]  sample;
    logic [7:0]          window_s;
    modport src   (output strobe, output sample, output window_s);
    modport meter (input strobe, input sample, input window_s);
endinterface : eamr_meter_if

// file: verilog/eamr_level_meter.sv
// level meter: sums magnitude of one bus over a window of whole seconds
// assumes one strobe per audio sample at the nominal sample rate
`timescale 1ns/1ps
module eamr_level_meter (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // samples from the router
    eamr_meter_if.meter      m,
    // window result
    output logic [47:0]      level_sum_o,
    output logic [23:0]      level_count_o,
    output logic             level_done_o
);
    logic [47:0] acc;
    logic [23:0] cnt;
    logic [23:0] target;
    logic [23:0] mag;
    logic [23:0] cnt_nx;
    logic        last;

    // a zero window falls back to the typical length
    always_comb begin
        target = {16'h0000, (m.window_s == 8'h00) ? eamr_pkg::WINDOW_TYPICAL_S : m.window_s}
               * {8'h00, eamr_pkg::SAMPLE_RATE_HZ};
        mag    = m.sample[23] ? 24'(-m.sample) : 24'(m.sample);
        cnt_nx = cnt + 24'h000001;
        last   = cnt_nx >= target;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            acc <= 48'h000000000000;
            cnt <= 24'h000000;
        end else if (m.strobe) begin
            acc <= last ? 48'h000000000000 : acc + {24'h000000, mag};
            cnt <= last ? 24'h000000 : cnt_nx;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            level_sum_o   <= 48'h000000000000;
            level_count_o <= 24'h000000;
            level_done_o  <= 1'b0;
        end else begin
            level_done_o <= m.strobe & last;
            if (m.strobe & last) begin
                level_sum_o   <= acc + {24'h000000, mag};
                level_count_o <= cnt_nx;
            end
        end
    end

    property p_window_len;
        @(posedge clk_i) disable iff (sys_rst_i)
        level_done_o |-> level_count_o >= $past(target);
    endproperty
    a_window_len: assert property (p_window_len) else $error("window ended early");
endmodule : eamr_level_meter

// file: verilog/eamr_mixer_router.sv
// audio source selection, 16x16 gain mixer and output routing
// assumes all ports share clk_i; sample_strobe_i pulses once per audio sample
`timescale 1ns/1ps
module eamr_mixer_router (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    sys_rst_i,
    // incoming samples
    input  wire logic                    sample_strobe_i,
    input  wire logic [15:0][23:0]       sdi_in_i,
    input  wire logic [3:0]              sdi_grp_present_i,
    input  wire logic [7:0][23:0]        aes_in_i,
    input  wire logic [3:0][23:0]        analog_in_i,
    input  wire logic [7:0][23:0]        dec_in_i,
    input  wire logic                    dec_is_71_i,
    input  wire logic [1:0][23:0]        enc_in_i,
    // source selection per input pair
    input  wire logic [7:0][1:0]         src_type_i,
    input  wire logic [7:0][2:0]         src_pair_i,
    input  wire logic [7:0][1:0]         pair_mode_i,
    input  wire logic [7:0]              pair_is_data_i,
    // mixer control
    input  wire logic [15:0][3:0]        mix_mode_i,
    input  wire logic                    matrix_wr_i,
    input  wire logic [3:0]              matrix_wr_ch_i,
    input  wire logic [15:0]             matrix_wr_row_i,
    input  wire logic                    gain_wr_i,
    input  wire logic [3:0]              gain_wr_ch_i,
    input  wire logic [7:0]              gain_wr_val_i,
    input  wire logic [15:0][7:0]        agc_gain_i,
    input  wire logic [15:0]             per_channel_gain_auto_enable_i,
    input  wire logic                    gain_control_master_i,
    // output control
    input  wire logic [3:0]              embed_group_enable_i,
    input  wire logic                    remove_embedded_audio_i,
    input  wire logic [3:0]              aes_port_is_input_i,
    input  wire logic                    encoder_insert_en_i,
    input  wire logic [2:0]              encoder_slot_select_i,
    input  wire logic [3:0]              encoder_to_aes_i,
    input  wire logic [3:0]              meter_bus_i,
    input  wire logic [7:0]              loudness_average_window_i,
    // outgoing samples and state
    output logic                         out_strobe_o,
    output logic [15:0][23:0]            sdi_out_o,
    output logic [15:0]                  sdi_out_valid_o,
    output logic [7:0][23:0]             aes_out_o,
    output logic [3:0]                   aes_out_en_o,
    output logic [15:0][7:0]             gain_o,
    output logic [15:0][15:0]            output_bus_matrix_o,
    output logic [47:0]                  level_sum_o,
    output logic [23:0]                  level_count_o,
    output logic                         level_done_o
);
    // ****************************************************************
    // decode helpers
    // ****************************************************************
    function automatic logic is_sur(input logic [3:0] m);
        is_sur = (m >= eamr_pkg::MIX_LEFT) && (m <= eamr_pkg::MIX_RREAR);
    endfunction : is_sur

    // channels a and b share gain and automatic gain
    function automatic logic linked(input int a, input int b, input logic [15:0][3:0] m);
        logic pr;
        pr = ((a >> 1) == (b >> 1))
           && (m[a] == eamr_pkg::MIX_PAIRED || m[b] == eamr_pkg::MIX_PAIRED);
        linked = (a == b) || pr || (is_sur(m[a]) && is_sur(m[b]));
    endfunction : linked

    // ****************************************************************
    // snapshot taken at the sample boundary
    // ****************************************************************
    eamr_pkg::eamr_smp_t [15:0] sh_sdi;
    eamr_pkg::eamr_smp_t [7:0]  sh_aes;
    eamr_pkg::eamr_smp_t [3:0]  sh_ana;
    eamr_pkg::eamr_smp_t [7:0]  sh_dec;
    eamr_pkg::eamr_smp_t [1:0]  sh_enc;
    logic [3:0]                 sh_present;
    logic                       sh_dec71;
    logic [7:0][1:0]            sh_src;
    logic [7:0][2:0]            sh_pair;
    logic [7:0]                 sh_data;
    logic [15:0][3:0]           sh_mix;
    logic [15:0][15:0]          sh_mtx;
    logic [15:0][7:0]           sh_gain;
    logic [15:0][7:0]           sh_agc;
    logic [15:0]                sh_auto;
    logic                       sh_master;
    logic [3:0]                 sh_embed;
    logic                       sh_remove;
    logic [3:0]                 sh_aes_in;
    logic                       sh_enc_en;
    logic [2:0]                 sh_slot;
    logic [3:0]                 sh_enc_aes;
    logic [3:0]                 sh_meter;
    logic [7:0]                 sh_window;
    logic                       tick;

    // everything that forms one output sample is frozen together, so a
    // software update halfway through a sample cannot tear it
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sh_mix    <= '0;
            sh_data   <= 8'h00;
            sh_src    <= '0;
            sh_pair   <= '0;
            sh_auto   <= 16'h0000;
            sh_master <= 1'b0;
            sh_embed  <= 4'h0;
            sh_remove <= 1'b0;
            sh_aes_in <= 4'hF;
            sh_enc_en <= 1'b0;
            sh_slot   <= 3'h0;
            sh_enc_aes <= 4'h0;
            sh_meter  <= 4'h0;
            sh_window <= 8'h00;
            sh_dec71  <= 1'b0;
        end else if (sample_strobe_i) begin
            sh_mix    <= mix_mode_i;
            for (int p = 0; p < eamr_pkg::NPAIR; p++) begin
                sh_data[p] <= (pair_mode_i[p] == eamr_pkg::PM_DATA)
                           || (pair_mode_i[p] == eamr_pkg::PM_AUTO && pair_is_data_i[p]);
            end
            sh_src    <= src_type_i;
            sh_pair   <= src_pair_i;
            sh_auto   <= per_channel_gain_auto_enable_i;
            sh_master <= gain_control_master_i;
            sh_embed  <= embed_group_enable_i;
            sh_remove <= remove_embedded_audio_i;
            sh_aes_in <= aes_port_is_input_i;
            sh_enc_en <= encoder_insert_en_i;
            sh_slot   <= encoder_slot_select_i;
            sh_enc_aes <= encoder_to_aes_i;
            sh_meter  <= meter_bus_i;
            sh_window <= loudness_average_window_i;
            sh_dec71  <= dec_is_71_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tick <= 1'b0;
        end else begin
            tick <= sample_strobe_i;
            if (sample_strobe_i) begin
                sh_sdi     <= sdi_in_i;
                sh_aes     <= aes_in_i;
                sh_ana     <= analog_in_i;
                sh_dec     <= dec_in_i;
                sh_enc     <= enc_in_i;
                sh_present <= sdi_grp_present_i;
                sh_mtx     <= output_bus_matrix_o;
                sh_gain    <= gain_o;
                sh_agc     <= agc_gain_i;
            end
        end
    end

    // ****************************************************************
    // gain and assignment matrix state
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (int k = 0; k < eamr_pkg::NCH; k++) gain_o[k] <= eamr_pkg::GAIN_UNITY;
        end else if (gain_wr_i) begin
            for (int k = 0; k < eamr_pkg::NCH; k++) begin
                if (linked(k, int'(gain_wr_ch_i), sh_mix)) gain_o[k] <= gain_wr_val_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (int k = 0; k < eamr_pkg::NCH; k++) begin
                output_bus_matrix_o[k] <= 16'(17'h00001 << k);
            end
        end else if (matrix_wr_i) begin
            output_bus_matrix_o[matrix_wr_ch_i] <= matrix_wr_row_i;
        end
    end

    // ****************************************************************
    // source selection and mixing
    // ****************************************************************
    eamr_pkg::eamr_smp_t [15:0] raw;
    eamr_pkg::eamr_smp_t [15:0] bus;
    logic [15:0]                data_ch;
    logic [15:0][9:0]           eg;

    // four selector groups of two pairs feed inputs 4g..4g+3
    always_comb begin
        for (int p = 0; p < eamr_pkg::NPAIR; p++) begin
            for (int s = 0; s < 2; s++) begin
                data_ch[2*p+s] = sh_data[p];
                unique case (sh_src[p])
                    eamr_pkg::SRC_SDI:    raw[2*p+s] = sh_sdi[2*sh_pair[p]+s];
                    eamr_pkg::SRC_AES:    raw[2*p+s] = sh_aes[2*sh_pair[p][1:0]+s];
                    eamr_pkg::SRC_ANALOG: raw[2*p+s] = sh_ana[2*sh_pair[p][0]+s];
                    eamr_pkg::SRC_DECODE: begin
                        // channels beyond what the codec carries read as silence
                        raw[2*p+s] = (4'(2*sh_pair[p][1:0]+s) <
                                      (sh_dec71 ? eamr_pkg::DEC_CH_71 : eamr_pkg::DEC_CH_51))
                                   ? sh_dec[2*sh_pair[p][1:0]+s] : 24'h000000;
                    end
                endcase
            end
        end
    end

    // gain per input only; a linked group follows its lowest member's agc
    always_comb begin
        for (int i = 0; i < eamr_pkg::NCH; i++) begin
            int ld;
            ld = i;
            for (int k = eamr_pkg::NCH - 1; k >= 0; k--) begin
                if (linked(k, i, sh_mix)) ld = k;
            end
            if (sh_master && sh_auto[ld]) begin
                eg[i] = 10'((16'(sh_gain[i]) * 16'(sh_agc[ld])) >> eamr_pkg::GAIN_FRAC);
            end else begin
                eg[i] = {2'b00, sh_gain[i]};
            end
        end
    end

    always_comb begin
        for (int b = 0; b < eamr_pkg::NCH; b++) begin
            logic signed [32:0] acc;
            logic signed [34:0] pr;
            acc = '0;
            pr  = '0;
            for (int i = 0; i < eamr_pkg::NCH; i++) begin
                pr = raw[i] * $signed({1'b0, eg[i]});
                // data channels never enter a sum
                if (sh_mtx[i][b] && !data_ch[i]) acc = acc + 33'(pr >>> eamr_pkg::GAIN_FRAC);
            end
            if (data_ch[b]) bus[b] = raw[b];
            else if (acc > eamr_pkg::ACC_MAX) bus[b] = 24'h7FFFFF;
            else if (acc < eamr_pkg::ACC_MIN) bus[b] = 24'h800000;
            else bus[b] = acc[23:0];
        end
    end

    // ****************************************************************
    // output routing
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            out_strobe_o    <= 1'b0;
            sdi_out_o       <= '0;
            sdi_out_valid_o <= 16'h0000;
        end else begin
            out_strobe_o <= tick;
            if (tick) begin
                for (int c = 0; c < eamr_pkg::NCH; c++) begin
                    if (sh_enc_en && (c >> 1) == int'(sh_slot)) begin
                        sdi_out_o[c]       <= sh_enc[c & 1];
                        sdi_out_valid_o[c] <= 1'b1;
                    end else if (sh_embed[c >> 2]) begin
                        sdi_out_o[c]       <= bus[c];
                        sdi_out_valid_o[c] <= 1'b1;
                    end else begin
                        // strip wins over pass-through of the incoming group
                        sdi_out_o[c]       <= sh_remove ? 24'h000000 : sh_sdi[c];
                        sdi_out_valid_o[c] <= !sh_remove && sh_present[c >> 2];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            aes_out_o    <= '0;
            aes_out_en_o <= 4'h0;
        end else if (tick) begin
            aes_out_en_o <= ~sh_aes_in;
            for (int c = 0; c < 2 * eamr_pkg::NAES; c++) begin
                if (sh_aes_in[c >> 1]) aes_out_o[c] <= 24'h000000;
                else if (sh_enc_aes[c >> 1]) aes_out_o[c] <= sh_enc[c & 1];
                else aes_out_o[c] <= bus[c];
            end
        end
    end

    // ****************************************************************
    // level meter on the chosen bus
    // ****************************************************************
    eamr_meter_if mtr ();
    assign mtr.strobe   = tick;
    assign mtr.sample   = bus[sh_meter];
    assign mtr.window_s = sh_window;

    eamr_level_meter u_meter (
        .clk_i         (clk_i),
        .sys_rst_i     (sys_rst_i),
        .m             (mtr.meter),
        .level_sum_o   (level_sum_o),
        .level_count_o (level_count_o),
        .level_done_o  (level_done_o)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_boundary;
        @(posedge clk_i) disable iff (sys_rst_i)
        sample_strobe_i |-> ##2 out_strobe_o;
    endproperty
    a_boundary: assert property (p_boundary) else $error("output not two cycles after strobe");

    property p_reset_state;
        @(posedge clk_i) sys_rst_i |=> gain_o[5] == eamr_pkg::GAIN_UNITY
            && output_bus_matrix_o[5] == 16'h0020;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad reset gain or matrix");

    property p_pair_link;
        @(posedge clk_i) disable iff (sys_rst_i)
        gain_wr_i && gain_wr_ch_i == 4'h8
        && (sh_mix[8] == eamr_pkg::MIX_PAIRED || sh_mix[9] == eamr_pkg::MIX_PAIRED)
        |=> gain_o[9] == $past(gain_wr_val_i) && gain_o[8] == gain_o[9];
    endproperty
    a_pair_link: assert property (p_pair_link) else $error("paired gain not linked");

    property p_group_gate;
        @(posedge clk_i) disable iff (sys_rst_i)
        tick && !sh_embed[1] && sh_remove && !(sh_enc_en && sh_slot[2:1] == 2'h1)
        |=> sdi_out_valid_o[7:4] == 4'h0;
    endproperty
    a_group_gate: assert property (p_group_gate) else $error("disabled group embedded");

    property p_aes_dir;
        @(posedge clk_i) disable iff (sys_rst_i)
        tick && sh_aes_in[2] |=> !aes_out_en_o[2] && aes_out_o[5:4] == '0;
    endproperty
    a_aes_dir: assert property (p_aes_dir) else $error("input aes port driven");

    property p_enc_slot;
        @(posedge clk_i) disable iff (sys_rst_i)
        tick && sh_enc_en |=> sdi_out_o[2*$past(sh_slot)+1] == $past(sh_enc[1])
            && sdi_out_valid_o[2*$past(sh_slot)];
    endproperty
    a_enc_slot: assert property (p_enc_slot) else $error("encoder pair misplaced");

    property p_data_bypass;
        @(posedge clk_i) disable iff (sys_rst_i)
        tick && data_ch[1] && sh_embed[0] && !(sh_enc_en && sh_slot == 3'h0)
        |=> sdi_out_o[1] == $past(raw[1]);
    endproperty
    a_data_bypass: assert property (p_data_bypass) else $error("data pair altered");

    property p_agc_gate;
        @(posedge clk_i) disable iff (sys_rst_i)
        !sh_master |-> eg[0] == {2'b00, sh_gain[0]};
    endproperty
    a_agc_gate: assert property (p_agc_gate) else $error("auto gain without master");

    property p_analog_pick;
        @(posedge clk_i) disable iff (sys_rst_i)
        sh_src[1] == eamr_pkg::SRC_ANALOG |-> raw[3] == sh_ana[2*sh_pair[1][0]+1];
    endproperty
    a_analog_pick: assert property (p_analog_pick) else $error("analog pair wrong");
endmodule : eamr_mixer_router

// file: sim/eamr_far_end.sv
// far-end model: sample strobe plus sdi and encoder samples toward the router
// assumes fire_i is a one-cycle request on clk_i
`timescale 1ns/1ps
module eamr_far_end (
    // clock, reset, request
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         fire_i,
    // samples toward the router
    output logic              strobe_o,
    output logic [15:0][23:0] sdi_o,
    output logic [1:0][23:0]  enc_o
);
    logic [23:0] lfsr;
    // own lfsr so the data stream does not disturb the bench's seeded draws
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) lfsr <= 24'hACE1;
        else if (fire_i) lfsr <= {lfsr[22:0], lfsr[23] ^ lfsr[22] ^ lfsr[21] ^ lfsr[16]};
    end
    always_ff @(posedge clk_i) strobe_o <= fire_i && !sys_rst_i;
    always_comb begin
        for (int i = 0; i < 16; i++) sdi_o[i] = lfsr + 24'(i * 24'h13579B);
        enc_o[0] = ~lfsr;
        enc_o[1] = lfsr ^ 24'h5A5A5A;
    end
endmodule : eamr_far_end

// file: sim/embedded_audio_mixer_router_tb_top.sv
// testbench top: random and corner-case samples through the mixer/router
// assumes the far-end model supplies strobes and sdi/encoder samples
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module embedded_audio_mixer_router_tb_top;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, fire = 1'b0, ostb, strobe;
    logic mwr = 1'b0, gwr = 1'b0, master = 1'b0, strip = 1'b0, enc_en = 1'b0;
    logic [15:0][23:0] sdi_in, sdi_out;
    logic [1:0][23:0]  enc;
    logic [7:0][23:0]  aes_in = '0, aes_out;
    logic [3:0][23:0]  ana = '0;
    logic [15:0]       valid, auto_en = '0, mrow = '0;
    logic [3:0]        grp_en = 4'hF, aes_inp = 4'hF, enc_aes = 4'h0, aes_en, mch = '0, gch = '0;
    logic [7:0][1:0]   src_type = '0, pmode = '0;
    logic [7:0][2:0]   src_pair;
    logic [7:0]        is_data = '0, gval = 8'h40;
    logic [15:0][3:0]  mix = '0;
    logic [15:0][7:0]  agc = '0, gain;
    logic [15:0][15:0] mtx;
    logic [2:0]        slot = '0;
    logic [23:0]       ex;
    int n_fail = 0, total_checks = 0;
    always #10 clk_i = ~clk_i;
    eamr_far_end FAR (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .fire_i(fire),
        .strobe_o(strobe), .sdi_o(sdi_in), .enc_o(enc));
    eamr_mixer_router DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sample_strobe_i(strobe),
        .sdi_in_i(sdi_in), .sdi_grp_present_i(4'hF), .aes_in_i(aes_in), .analog_in_i(ana),
        .dec_in_i('0), .dec_is_71_i(1'b0), .enc_in_i(enc), .src_type_i(src_type),
        .src_pair_i(src_pair), .pair_mode_i(pmode), .pair_is_data_i(is_data),
        .mix_mode_i(mix), .matrix_wr_i(mwr), .matrix_wr_ch_i(mch), .matrix_wr_row_i(mrow),
        .gain_wr_i(gwr), .gain_wr_ch_i(gch), .gain_wr_val_i(gval), .agc_gain_i(agc),
        .per_channel_gain_auto_enable_i(auto_en), .gain_control_master_i(master),
        .embed_group_enable_i(grp_en), .remove_embedded_audio_i(strip),
        .aes_port_is_input_i(aes_inp), .encoder_insert_en_i(enc_en),
        .encoder_slot_select_i(slot), .encoder_to_aes_i(enc_aes), .meter_bus_i(4'h0),
        .loudness_average_window_i(8'h01), .out_strobe_o(ostb), .sdi_out_o(sdi_out),
        .sdi_out_valid_o(valid), .aes_out_o(aes_out), .aes_out_en_o(aes_en), .gain_o(gain),
        .output_bus_matrix_o(mtx), .level_sum_o(), .level_count_o(), .level_done_o());
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [23:0] sat_sum(logic [23:0] a, logic [23:0] b);
        logic signed [24:0] s;
        s = $signed({a[23], a}) + $signed({b[23], b});
        if (s > 25'sh07FFFFF) return 24'h7FFFFF;
        if (s < 25'sh1800000) return 24'h800000;
        return s[23:0];
    endfunction : sat_sum
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic run_sample();
        @(posedge clk_i) fire <= 1'b1;
        @(posedge clk_i) fire <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            #1;
            if (ostb === 1'b1) return;
            @(posedge clk_i);
        end
        n_fail++;
        complete_run();
    endtask : run_sample
    initial begin
        void'($urandom(64));
        for (int p = 0; p < 8; p++) src_pair[p] = 3'(p);
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1;
        `CHK(aes_en, 4'h0)
        for (int k = 0; k < 16; k++) begin
            `CHK(gain[k], 8'h40)
            `CHK(mtx[k], 16'h0001 << k)
        end
        repeat (8) begin
            @(posedge clk_i);
            slot <= 3'($urandom);
            enc_en <= 1'($urandom);
            aes_inp <= 4'($urandom);
            enc_aes <= 4'($urandom);
            for (int a = 0; a < 4; a++) ana[a] <= 24'($urandom);
            run_sample();
            for (int c = 0; c < 16; c++) begin
                ex = (enc_en && c / 2 == slot) ? enc[c % 2] : sdi_in[c];
                `CHK(sdi_out[c], ex)
            end
            for (int c = 0; c < 8; c++) begin
                ex = aes_inp[c / 2] ? 24'h0 : enc_aes[c / 2] ? enc[c % 2] : sdi_in[c];
                `CHK(aes_out[c], ex)
                `CHK(aes_en[c / 2], !aes_inp[c / 2])
            end
        end
        // fan-in of channels 0 and 1 onto bus 0, then the same pair as data
        @(posedge clk_i) {enc_en, enc_aes, mwr, mch, mrow} <= {5'h0, 1'b1, 4'h1, 16'h0003};
        @(posedge clk_i) {mwr, mix[8]} <= {1'b0, eamr_pkg::MIX_PAIRED};
        run_sample();
        `CHK(mtx[1], 16'h0003)
        `CHK(sdi_out[0], sat_sum(sdi_in[0], sdi_in[1]))
        @(posedge clk_i) pmode[0] <= eamr_pkg::PM_DATA;
        run_sample();
        `CHK(sdi_out[0], sdi_in[0])
        `CHK(sdi_out[1], sdi_in[1])
        @(posedge clk_i) {gwr, gch, gval} <= {1'b1, 4'h8, 8'($urandom)};
        @(posedge clk_i) gwr <= 1'b0;
        #1;
        `CHK(gain[9], gval)
        `CHK(gain[10], 8'h40)
        // pair 1 from analog 3/4, channel 2 at half automatic gain, channel 3 not enabled
        @(posedge clk_i) {master, auto_en[2], agc[2], src_type[1], src_pair[1]} <=
            {2'b11, 8'h20, eamr_pkg::SRC_ANALOG, 3'h1};
        run_sample();
        ex = 24'($signed(ana[2]) >>> 1);
        `CHK(sdi_out[2], ex)
        `CHK(sdi_out[3], ana[3])
        @(posedge clk_i) {grp_en, strip} <= {4'hC, 1'b1};
        run_sample();
        `CHK(valid[7:0], 8'h00)
        `CHK(sdi_out[0], 24'h0)
        complete_run();
    end
endmodule : embedded_audio_mixer_router_tb_top
